/* logic/vspga_assign_reg.v */
`timescale 1ns/10ps
`default_nettype none
`include "vspga_defs.vh"
// one sticky assignment register with its published count
module vspga_assign_reg #(
    parameter WIDTH = 12,
    parameter CNT_W = 4
) (
    input wire clk_i,
    input wire sticky_rst_i,
    input wire strap_load_i,
    input wire [WIDTH-1:0] strap_default_i,
    input wire wr_i,
    input wire [WIDTH-1:0] wr_data_i,
    input wire top_bit_en_i,
    input wire commit_i,
    output reg [WIDTH-1:0] assign_o,
    output reg [CNT_W-1:0] count_o
);
    reg [WIDTH-1:0] assign_next;
    reg [CNT_W-1:0] count_next;
    integer i;

    // next value: strap default, then register write; top bit reserved when disabled
    always @* begin
        assign_next = assign_o;
        if (strap_load_i) begin
            assign_next = strap_default_i;
        end else if (wr_i) begin
            assign_next = wr_data_i;
        end
        if (!top_bit_en_i) begin
            assign_next[WIDTH-1] = 1'b0;
        end
    end

    // population count of the held bits
    always @* begin
        count_next = {CNT_W{1'b0}};
        for (i = 0; i < WIDTH; i = i + 1) begin
            count_next = count_next + {{(CNT_W-1){1'b0}}, assign_o[i]};
        end
    end

    // sticky storage, cleared only by the sticky reset
    always @(posedge clk_i or posedge sticky_rst_i) begin
        if (sticky_rst_i) begin
            assign_o <= {WIDTH{1'b0}};
            count_o <= {CNT_W{1'b0}};
        end else begin
            assign_o <= assign_next;
            if (commit_i) begin
                count_o <= count_next;
            end
        end
    end
endmodule // vspga_assign_reg
`default_nettype wire

/* logic/vspga_defs.vh */
`ifndef VSPGA_DEFS_VH
`define VSPGA_DEFS_VH
// register offsets inside port 0 management space
`define VSPGA_VS3_ASSIGN_OFS 12'h65C
`define VSPGA_VS4_ASSIGN_OFS 12'h660
`define VSPGA_VS5_ASSIGN_OFS 12'h664
// selector registers (remap of signals to ports)
`define VSPGA_SEL0_OFS 12'h6A0
`define VSPGA_SEL1_OFS 12'h6A4
`define VSPGA_SEL2_OFS 12'h6A8
// commit register and its bit
`define VSPGA_COMMIT_OFS 12'h64C
`define VSPGA_COMMIT_BIT 0
// assignment field
`define VSPGA_ASSIGN_W 12
`define VSPGA_TOP_BIT 11
`define VSPGA_CNT_W 4
`define VSPGA_SEL_W 5
// selector field positions
`define VSPGA_SEL_F0_LSB 0
`define VSPGA_SEL_F1_LSB 8
`define VSPGA_SEL_F2_LSB 16
`define VSPGA_SEL_F3_LSB 24
// selector reset values: four port numbers per register
`define VSPGA_SEL0_RST 32'h03020100
`define VSPGA_SEL1_RST 32'h0B0A0908
`define VSPGA_SEL2_RST 32'h13121110
`define VSPGA_SEL_MASK 32'h1F1F1F1F
`define VSPGA_ZERO32 32'h00000000
`endif

/* logic/vspga_vs_port_good_assign.v */
// Behaviour
// - Each assignment register holds twelve bits 11..0 and bit x controls only link_good_out x.
// - A set bit puts that link_good signal into the register's virtual switch, a clear bit keeps it out.
// - When the commit bit is written, each switch's 4-bit count shows how many of its bits are set.
// - Bit 11 works only with four to six virtual switches enabled and is reserved otherwise.
// - By default link_good signals 11..0 map to ports 19,18,17,16,11,10,9,8,3,2,1,0.
// - Any link_good signal can be remapped to another port through the selector registers.
// - In virtual-switch mode the VS4 and VS5 registers sit at 660h and 664h in port 0.
`timescale 1ns/10ps
`default_nettype none
`include "vspga_defs.vh"
module vspga_vs_port_good_assign #(
    parameter WIDTH = 12,
    parameter CNT_W = 4,
    parameter ADDR_W = 12
) (
    input wire clk_i,
    input wire sys_rst_i,
    input wire sticky_rst_i,
    input wire strap_load_i,
    input wire [WIDTH-1:0] vs3_strap_default_i,
    input wire [WIDTH-1:0] vs4_strap_default_i,
    input wire [WIDTH-1:0] vs5_strap_default_i,
    input wire vs_mode_i,
    input wire [2:0] vs_count_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [ADDR_W-1:0] reg_addr_i,
    input wire [31:0] reg_wdata_i,
    input wire [WIDTH-1:0] link_good_i,
    output reg [31:0] reg_rdata_o,
    output reg [WIDTH-1:0] vs3_link_good_o,
    output reg [WIDTH-1:0] vs4_link_good_o,
    output reg [WIDTH-1:0] vs5_link_good_o,
    output reg [CNT_W-1:0] vs3_assigned_pin_count_o,
    output reg [CNT_W-1:0] vs4_assigned_pin_count_o,
    output reg [CNT_W-1:0] vs5_assigned_pin_count_o,
    output reg [WIDTH*5-1:0] link_good_port_o
);
    wire [WIDTH-1:0] vs3_assign;
    wire [WIDTH-1:0] vs4_assign;
    wire [WIDTH-1:0] vs5_assign;
    wire [CNT_W-1:0] vs3_cnt;
    wire [CNT_W-1:0] vs4_cnt;
    wire [CNT_W-1:0] vs5_cnt;
    wire top_bit_en;
    wire commit;
    wire wr_vs3;
    wire wr_vs4;
    wire wr_vs5;
    reg [31:0] sel0_reg;
    reg [31:0] sel1_reg;
    reg [31:0] sel2_reg;
    reg [31:0] rdata_next;
    reg [WIDTH*5-1:0] port_next;

    // bit 11 live only for four, five or six virtual switches
    assign top_bit_en = vs_mode_i && (vs_count_i >= 3'h4) && (vs_count_i <= 3'h6);
    assign commit = reg_wr_i && (reg_addr_i == `VSPGA_COMMIT_OFS)
        && reg_wdata_i[`VSPGA_COMMIT_BIT];
    // register decode; upper data bits dropped on write
    assign wr_vs3 = reg_wr_i && vs_mode_i && (reg_addr_i == `VSPGA_VS3_ASSIGN_OFS);
    assign wr_vs4 = reg_wr_i && vs_mode_i && (reg_addr_i == `VSPGA_VS4_ASSIGN_OFS);
    assign wr_vs5 = reg_wr_i && vs_mode_i && (reg_addr_i == `VSPGA_VS5_ASSIGN_OFS);

    vspga_assign_reg #(.WIDTH(WIDTH), .CNT_W(CNT_W)) u_vs3 (
        .clk_i(clk_i),
        .sticky_rst_i(sticky_rst_i),
        .strap_load_i(strap_load_i),
        .strap_default_i(vs3_strap_default_i),
        .wr_i(wr_vs3),
        .wr_data_i(reg_wdata_i[WIDTH-1:0]),
        .top_bit_en_i(top_bit_en),
        .commit_i(commit),
        .assign_o(vs3_assign),
        .count_o(vs3_cnt)
    );
    vspga_assign_reg #(.WIDTH(WIDTH), .CNT_W(CNT_W)) u_vs4 (
        .clk_i(clk_i),
        .sticky_rst_i(sticky_rst_i),
        .strap_load_i(strap_load_i),
        .strap_default_i(vs4_strap_default_i),
        .wr_i(wr_vs4),
        .wr_data_i(reg_wdata_i[WIDTH-1:0]),
        .top_bit_en_i(top_bit_en),
        .commit_i(commit),
        .assign_o(vs4_assign),
        .count_o(vs4_cnt)
    );
    vspga_assign_reg #(.WIDTH(WIDTH), .CNT_W(CNT_W)) u_vs5 (
        .clk_i(clk_i),
        .sticky_rst_i(sticky_rst_i),
        .strap_load_i(strap_load_i),
        .strap_default_i(vs5_strap_default_i),
        .wr_i(wr_vs5),
        .wr_data_i(reg_wdata_i[WIDTH-1:0]),
        .top_bit_en_i(top_bit_en),
        .commit_i(commit),
        .assign_o(vs5_assign),
        .count_o(vs5_cnt)
    );

    // selector registers, sticky, default port map
    always @(posedge clk_i or posedge sticky_rst_i) begin
        if (sticky_rst_i) begin
            sel0_reg <= `VSPGA_SEL0_RST;
            sel1_reg <= `VSPGA_SEL1_RST;
            sel2_reg <= `VSPGA_SEL2_RST;
        end else if (reg_wr_i) begin
            if (reg_addr_i == `VSPGA_SEL0_OFS) begin
                sel0_reg <= reg_wdata_i & `VSPGA_SEL_MASK;
            end
            if (reg_addr_i == `VSPGA_SEL1_OFS) begin
                sel1_reg <= reg_wdata_i & `VSPGA_SEL_MASK;
            end
            if (reg_addr_i == `VSPGA_SEL2_OFS) begin
                sel2_reg <= reg_wdata_i & `VSPGA_SEL_MASK;
            end
        end
    end

    // flatten selector fields into the per-signal port numbers
    always @* begin
        port_next = {sel2_reg[`VSPGA_SEL_F3_LSB +: `VSPGA_SEL_W],
            sel2_reg[`VSPGA_SEL_F2_LSB +: `VSPGA_SEL_W],
            sel2_reg[`VSPGA_SEL_F1_LSB +: `VSPGA_SEL_W],
            sel2_reg[`VSPGA_SEL_F0_LSB +: `VSPGA_SEL_W],
            sel1_reg[`VSPGA_SEL_F3_LSB +: `VSPGA_SEL_W],
            sel1_reg[`VSPGA_SEL_F2_LSB +: `VSPGA_SEL_W],
            sel1_reg[`VSPGA_SEL_F1_LSB +: `VSPGA_SEL_W],
            sel1_reg[`VSPGA_SEL_F0_LSB +: `VSPGA_SEL_W],
            sel0_reg[`VSPGA_SEL_F3_LSB +: `VSPGA_SEL_W],
            sel0_reg[`VSPGA_SEL_F2_LSB +: `VSPGA_SEL_W],
            sel0_reg[`VSPGA_SEL_F1_LSB +: `VSPGA_SEL_W],
            sel0_reg[`VSPGA_SEL_F0_LSB +: `VSPGA_SEL_W]};
    end

    // read mux; reserved upper bits read zero
    always @* begin
        rdata_next = `VSPGA_ZERO32;
        case (reg_addr_i)
            `VSPGA_VS3_ASSIGN_OFS: rdata_next[WIDTH-1:0] = vs3_assign;
            `VSPGA_VS4_ASSIGN_OFS: rdata_next[WIDTH-1:0] = vs4_assign;
            `VSPGA_VS5_ASSIGN_OFS: rdata_next[WIDTH-1:0] = vs5_assign;
            `VSPGA_SEL0_OFS: rdata_next = sel0_reg;
            `VSPGA_SEL1_OFS: rdata_next = sel1_reg;
            `VSPGA_SEL2_OFS: rdata_next = sel2_reg;
            default: rdata_next = `VSPGA_ZERO32;
        endcase
        if (!vs_mode_i && (reg_addr_i != `VSPGA_SEL0_OFS) && (reg_addr_i != `VSPGA_SEL1_OFS)
            && (reg_addr_i != `VSPGA_SEL2_OFS)) begin
            rdata_next = `VSPGA_ZERO32;
        end
    end

    // registered outputs; each switch sees only its own signals
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            reg_rdata_o <= `VSPGA_ZERO32;
            vs3_link_good_o <= {WIDTH{1'b0}};
            vs4_link_good_o <= {WIDTH{1'b0}};
            vs5_link_good_o <= {WIDTH{1'b0}};
            vs3_assigned_pin_count_o <= {CNT_W{1'b0}};
            vs4_assigned_pin_count_o <= {CNT_W{1'b0}};
            vs5_assigned_pin_count_o <= {CNT_W{1'b0}};
            link_good_port_o <= {(WIDTH*5){1'b0}};
        end else begin
            if (reg_rd_i) begin
                reg_rdata_o <= rdata_next;
            end
            vs3_link_good_o <= link_good_i & vs3_assign;
            vs4_link_good_o <= link_good_i & vs4_assign;
            vs5_link_good_o <= link_good_i & vs5_assign;
            vs3_assigned_pin_count_o <= vs3_cnt;
            vs4_assigned_pin_count_o <= vs4_cnt;
            vs5_assigned_pin_count_o <= vs5_cnt;
            link_good_port_o <= port_next;
        end
    end
endmodule // vspga_vs_port_good_assign
`default_nettype wire

/* testbench/vs_port_good_assignment_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin err_total++; \
    $display("[FAIL] %0t mismatch", $time); end end
module vs_port_good_assignment_tb;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic sticky_rst_i = 1'b1;
    logic strap_load_i = 1'b0;
    logic vs_mode_i = 1'b1;
    logic [2:0] vs_count_i = 3'h4;
    logic [11:0] link_good_i = 12'hFFF;
    logic reg_wr_i, reg_rd_i;
    logic [11:0] reg_addr_i;
    logic [31:0] reg_wdata_i, reg_rdata_o, d;
    logic [11:0] lg [3];
    logic [3:0] cnt [3];
    logic [59:0] port_map;
    logic [11:0] pat [3] = '{12'h7A5, 12'hC3C, 12'h801};
    logic [31:0] sel_rst [3] = '{32'h03020100, 32'h0B0A0908, 32'h13121110};
    // default port of each signal, signal 11 in the top field
    logic [59:0] port_dflt = {5'h13, 5'h12, 5'h11, 5'h10, 5'h0B, 5'h0A, 5'h09, 5'h08,
        5'h03, 5'h02, 5'h01, 5'h00};
    int err_total = 0;
    int tests_run = 0;
    // 20 MHz clock
    always #25 clk_i = ~clk_i;
    vspga_host i_host (.clk_i, .rdata_i(reg_rdata_o), .wr_o(reg_wr_i), .rd_o(reg_rd_i),
        .addr_o(reg_addr_i), .wdata_o(reg_wdata_i));
    vspga_vs_port_good_assign i_dut (.clk_i, .sys_rst_i, .sticky_rst_i, .strap_load_i,
        .vs3_strap_default_i(12'h5A5), .vs4_strap_default_i(12'hA5A),
        .vs5_strap_default_i(12'h3C3), .vs_mode_i, .vs_count_i, .reg_wr_i, .reg_rd_i,
        .reg_addr_i, .reg_wdata_i, .link_good_i, .reg_rdata_o, .vs3_link_good_o(lg[0]),
        .vs4_link_good_o(lg[1]), .vs5_link_good_o(lg[2]), .vs3_assigned_pin_count_o(cnt[0]),
        .vs4_assigned_pin_count_o(cnt[1]), .vs5_assigned_pin_count_o(cnt[2]),
        .link_good_port_o(port_map));
    // verdict and end of run
    task automatic stop_test();
        $display("checks %0d errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // hang guard
    initial begin
        repeat (4000) @(posedge clk_i);
        err_total++;
        stop_test();
    end
    // test sequence
    initial begin
        repeat (10) @(negedge clk_i);
        sys_rst_i = 1'b0;
        sticky_rst_i = 1'b0;
        for (int k = 0; k < 3; k++) begin
            i_host.read(12'h6A0 + 12'(k * 4), d);
            `CHK(d, sel_rst[k])
        end
        `CHK(port_map, port_dflt)
        for (int k = 0; k < 3; k++) begin
            i_host.write(12'h65C + 12'(k * 4), {20'hFFFFF, pat[k]});
            i_host.read(12'h65C + 12'(k * 4), d);
            `CHK(d, {20'h0, pat[k]})
            `CHK(cnt[k], 4'h0)
        end
        link_good_i = 12'h5A5;
        repeat (2) @(negedge clk_i);
        for (int k = 0; k < 3; k++) `CHK(lg[k], pat[k] & 12'h5A5)
        i_host.commit();
        repeat (3) @(negedge clk_i);
        for (int k = 0; k < 3; k++) `CHK(cnt[k], 4'($countones(pat[k])))
        for (int n = 0; n < 8; n++) begin
            vs_count_i = 3'(n);
            i_host.write(12'h660, 32'h800);
            i_host.read(12'h660, d);
            `CHK(d, (n >= 4 && n <= 6) ? 32'h800 : 32'h0)
        end
        vs_mode_i = 1'b0;
        vs_count_i = 3'h5;
        i_host.write(12'h65C, 32'h0);
        i_host.read(12'h65C, d);
        `CHK(d, 32'h0)
        vs_mode_i = 1'b1;
        i_host.read(12'h65C, d);
        `CHK(d, {20'h0, pat[0]})
        i_host.write(12'h6A0, 32'hFFFFFF13);
        i_host.read(12'h6A0, d);
        `CHK(d, 32'h1F1F1F13)
        `CHK(port_map[4:0], 5'h13)
        i_host.read(12'h700, d);
        `CHK(d, 32'h0)
        sys_rst_i = 1'b1;
        repeat (2) @(negedge clk_i);
        sys_rst_i = 1'b0;
        // bit 11 was cleared while the switch count lay outside four to six
        i_host.read(12'h664, d);
        `CHK(d, {20'h0, pat[2] & 12'h7FF})
        strap_load_i = 1'b1;
        i_host.read(12'h660, d);
        strap_load_i = 1'b0;
        `CHK(d, 32'hA5A)
        stop_test();
    end
endmodule // vs_port_good_assignment_tb
`default_nettype wire

/* testbench/vspga_host.sv */
`timescale 1ns/10ps
`default_nettype none
// management port host: one strobe per access, released lines scrambled
module vspga_host (
    input wire logic clk_i,
    input wire logic [31:0] rdata_i,
    output logic wr_o,
    output logic rd_o,
    output logic [11:0] addr_o,
    output logic [31:0] wdata_o
);
    // idle bus at time zero
    initial begin
        wr_o = 1'b0;
        rd_o = 1'b0;
        addr_o = 12'h0;
        wdata_o = 32'h0;
    end
    // write strobe held over one rising edge
    task automatic write(input logic [11:0] a, input logic [31:0] d);
        @(negedge clk_i);
        addr_o = a;
        wdata_o = d;
        wr_o = 1'b1;
        @(negedge clk_i);
        wr_o = 1'b0;
        addr_o = ~a;
        wdata_o = ~d;
    endtask
    // read strobe over one edge, data taken after the answering edge
    task automatic read(input logic [11:0] a, output logic [31:0] d);
        @(negedge clk_i);
        addr_o = a;
        rd_o = 1'b1;
        @(negedge clk_i);
        rd_o = 1'b0;
        addr_o = ~a;
        @(negedge clk_i);
        d = rdata_i;
    endtask
    // publish the assignments to the counts
    task automatic commit();
        write(12'h64C, 32'h1);
    endtask
endmodule // vspga_host
`default_nettype wire

/* testbench/vspga_vs_port_good_assign_sva.sv */
`timescale 1ns/10ps
`default_nettype none
// port-level checks on register reads, gating and counts
module vspga_sva #(parameter WIDTH = 12, parameter CNT_W = 4, parameter ADDR_W = 12) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic sticky_rst_i,
    input wire logic strap_load_i,
    input wire logic [WIDTH-1:0] vs4_strap_default_i,
    input wire logic vs_mode_i,
    input wire logic [2:0] vs_count_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic [WIDTH-1:0] link_good_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic [WIDTH-1:0] vs4_link_good_o,
    input wire logic [CNT_W-1:0] vs4_assigned_pin_count_o
);
    // address, mode and commit decodes
    wire logic asn = reg_addr_i[1:0] == 2'h0 && reg_addr_i >= 12'h65C && reg_addr_i <= 12'h664;
    wire logic top_ok = vs_mode_i && vs_count_i >= 3'h4 && vs_count_i <= 3'h6;
    wire logic cw = reg_wr_i && reg_addr_i == 12'h64C && reg_wdata_i[0];
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i || sticky_rst_i);
    // register reads
    property p_off; reg_rd_i && asn && !vs_mode_i |=> reg_rdata_o == 32'h0; endproperty
    a_off: assert property (p_off) else $error("read not gated");
    property p_hi; reg_rd_i && asn |=> reg_rdata_o[31:12] == 20'h0; endproperty
    a_hi: assert property (p_hi) else $error("upper bits set");
    property p_sel; reg_rd_i && reg_addr_i == 12'h6A4
        |=> (reg_rdata_o & 32'hE0E0E0E0) == 32'h0; endproperty
    a_sel: assert property (p_sel) else $error("selector spare bits");
    property p_hold; !reg_rd_i |=> $stable(reg_rdata_o); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    // outputs and counts
    property p_and; (vs4_link_good_o & ~$past(link_good_i)) == 12'h0; endproperty
    a_and: assert property (p_and) else $error("signal without source");
    property p_b11; !top_ok [*2] |=> vs4_link_good_o[11] == 1'b0; endproperty
    a_b11: assert property (p_b11) else $error("bit 11 live");
    // the output reloads the held count on the first edge after an ordinary reset is released
    property p_cnt; $changed(vs4_assigned_pin_count_o) && !$past(sys_rst_i, 2)
        |-> $past(cw, 2); endproperty
    a_cnt: assert property (p_cnt) else $error("count moved");
    property p_strap; strap_load_i && top_ok ##1 reg_rd_i && reg_addr_i == 12'h660 && top_ok
        |=> reg_rdata_o[11:0] == $past(vs4_strap_default_i, 2); endproperty
    a_strap: assert property (p_strap) else $error("strap not loaded");
endmodule // vspga_sva
bind vspga_vs_port_good_assign vspga_sva #(.WIDTH(WIDTH), .CNT_W(CNT_W), .ADDR_W(ADDR_W)) i_sva (
    .clk_i, .sys_rst_i, .sticky_rst_i, .strap_load_i, .vs4_strap_default_i, .vs_mode_i,
    .vs_count_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .link_good_i, .reg_rdata_o,
    .vs4_link_good_o, .vs4_assigned_pin_count_o);
`default_nettype wire
